// ==== logic/mct_pkg.sv ====
package mct_pkg;

   localparam int NUM_MATCH = 4;
   localparam int NUM_CAP   = 2;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int WIDE_W    = 32;
   localparam int NARROW_W  = 16;

   // Register byte addresses
   localparam logic [7:0] OFS_STATUS    = 8'h00;
   localparam logic [7:0] OFS_MASK      = 8'h04;
   localparam logic [7:0] OFS_CTRL      = 8'h08;
   localparam logic [7:0] OFS_COUNT     = 8'h0C;
   localparam logic [7:0] OFS_PRESCALE  = 8'h10;
   localparam logic [7:0] OFS_PRECOUNT  = 8'h14;
   localparam logic [7:0] OFS_MATCHCTRL = 8'h18;
   localparam logic [7:0] OFS_OUTCTRL   = 8'h1C;
   localparam logic [7:0] OFS_CAPCTRL   = 8'h20;
   localparam logic [7:0] OFS_COUNTCTRL = 8'h24;
   localparam logic [7:0] OFS_OUTVAL    = 8'h28;
   localparam logic [7:0] OFS_MATCH0    = 8'h30;
   localparam logic [7:0] OFS_CAP0      = 8'h40;

   // Control register fields
   localparam int CTRL_EN  = 0;
   localparam int CTRL_RST = 1;
   localparam int CTRL_W   = 2;

   // Per-match control fields, MC_W bits per channel
   localparam int MC_INT  = 0;
   localparam int MC_RST  = 1;
   localparam int MC_STOP = 2;
   localparam int MC_W    = 3;

   // Per-capture control fields, CC_W bits per channel
   localparam int CC_RISE = 0;
   localparam int CC_FALL = 1;
   localparam int CC_INT  = 2;
   localparam int CC_W    = 3;

   localparam int OUT_W = 2;

   // Count control fields
   localparam int CM_MODE_LSB = 0;
   localparam int CM_SEL      = 2;
   localparam int CM_CLR_EN   = 3;
   localparam int CM_CLR_FALL = 4;
   localparam int CM_CLR_SEL  = 5;
   localparam int CM_W        = 6;

   // Status bits: matches low, captures above
   localparam int ST_CAP_LSB = NUM_MATCH;
   localparam int ST_W       = NUM_MATCH + NUM_CAP;

   localparam logic [DATA_W-1:0] REG_RESET = 32'h0;

   typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} out_act_e;
   typedef enum logic [1:0] {MODE_TIMER, MODE_RISE, MODE_FALL, MODE_BOTH} count_mode_e;

endpackage : mct_pkg

// ==== logic/mct_if.sv ====
`timescale 1ns/1ps
interface mct_if #(parameter int W = 32);
   logic [W-1:0]                  count;
   logic [W-1:0]                  matchVal [mct_pkg::NUM_MATCH];
   logic [mct_pkg::NUM_MATCH-1:0] matchHit;
   logic [mct_pkg::NUM_CAP-1:0]   capRiseEn;
   logic [mct_pkg::NUM_CAP-1:0]   capFallEn;
   logic [mct_pkg::NUM_CAP-1:0]   capRise;
   logic [mct_pkg::NUM_CAP-1:0]   capFall;
   logic [mct_pkg::NUM_CAP-1:0]   capEvt;
   logic [W-1:0]                  capVal [mct_pkg::NUM_CAP];

   modport top (output count, matchVal, capRiseEn, capFallEn,
                input matchHit, capRise, capFall, capEvt, capVal);
   modport match (input count, matchVal, output matchHit);
   modport cap (input count, capRiseEn, capFallEn,
                output capRise, capFall, capEvt, capVal);
endinterface : mct_if

// ==== logic/match_unit.sv ====
`timescale 1ns/1ps
module match_unit (
   input wire logic mclk,
   input wire logic rstn,
   mct_if.match     bus
);

   logic [mct_pkg::NUM_MATCH-1:0] eq;
   logic [mct_pkg::NUM_MATCH-1:0] eqQ;

   always_comb begin
      for (int i = 0; i < mct_pkg::NUM_MATCH; i++) begin
         eq[i] = (bus.count == bus.matchVal[i]);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         eqQ <= '0;
      end else begin
         eqQ <= eq;
      end
   end

   // One event per arrival at the match value, not one per cycle held
   assign bus.matchHit = eq & ~eqQ;

endmodule : match_unit

// ==== logic/capture_unit.sv ====
`timescale 1ns/1ps
module capture_unit (
   input wire logic                        mclk,
   input wire logic                        rstn,
   input wire logic [mct_pkg::NUM_CAP-1:0] capIn,
   mct_if.cap                              bus
);

   logic [mct_pkg::NUM_CAP-1:0] sync1Q;
   logic [mct_pkg::NUM_CAP-1:0] sync2Q;
   logic [mct_pkg::NUM_CAP-1:0] sync3Q;
   logic [mct_pkg::NUM_CAP-1:0] levelQ;
   logic [mct_pkg::NUM_CAP-1:0] change;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync1Q <= '0;
         sync2Q <= '0;
         sync3Q <= '0;
      end else begin
         sync1Q <= capIn;
         sync2Q <= sync1Q;
         sync3Q <= sync2Q;
      end
   end

   // A new level counts only once the last two stages agree
   assign change = ~(sync2Q ^ sync3Q) & (sync3Q ^ levelQ);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         levelQ <= '0;
      end else begin
         levelQ <= levelQ ^ change;
      end
   end

   assign bus.capRise = change & sync3Q;
   assign bus.capFall = change & ~sync3Q;
   assign bus.capEvt  = (bus.capRise & bus.capRiseEn) | (bus.capFall & bus.capFallEn);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int c = 0; c < mct_pkg::NUM_CAP; c++) begin
            bus.capVal[c] <= '0;
         end
      end else begin
         for (int c = 0; c < mct_pkg::NUM_CAP; c++) begin
            if (bus.capEvt[c]) begin
               bus.capVal[c] <= bus.count;
            end
         end
      end
   end

endmodule : capture_unit

// ==== logic/match_capture_counter_timer.sv ====
`timescale 1ns/1ps
module match_capture_counter_timer #(
   parameter int CNT_W = mct_pkg::WIDE_W
) (
   input  wire logic                          mclk,
   input  wire logic                          rstn,
   input  wire logic [mct_pkg::ADDR_W-1:0]    addr,
   input  wire logic [mct_pkg::DATA_W-1:0]    wdata,
   input  wire logic                          wrStb,
   input  wire logic                          rdStb,
   output logic      [mct_pkg::DATA_W-1:0]    rdata,
   input  wire logic [mct_pkg::NUM_CAP-1:0]   capIn,
   output logic      [mct_pkg::NUM_MATCH-1:0] matchOut,
   output logic                               irq
);

   localparam int NM = mct_pkg::NUM_MATCH;
   localparam int NC = mct_pkg::NUM_CAP;

   mct_if #(.W(CNT_W)) bus ();

   logic [mct_pkg::ST_W-1:0]      statusQ;
   logic [mct_pkg::ST_W-1:0]      maskQ;
   logic [mct_pkg::CTRL_W-1:0]    ctrlQ;
   logic [CNT_W-1:0]              countQ;
   logic [CNT_W-1:0]              prescaleQ;
   logic [CNT_W-1:0]              preCountQ;
   logic [NM*mct_pkg::MC_W-1:0]   matchCtrlQ;
   logic [NM*mct_pkg::OUT_W-1:0]  outCtrlQ;
   logic [NC*mct_pkg::CC_W-1:0]   capCtrlQ;
   logic [mct_pkg::CM_W-1:0]      countCtrlQ;
   logic [NM-1:0]                 outQ;
   logic [CNT_W-1:0]              matchQ [NM];
   logic [mct_pkg::DATA_W-1:0]    rdataQ;
   logic [mct_pkg::DATA_W-1:0]    rdMux;

   logic [NM-1:0]                 matchInt;
   logic [NM-1:0]                 matchRst;
   logic [NM-1:0]                 matchStop;
   logic [NC-1:0]                 capInt;
   logic [mct_pkg::ST_W-1:0]      statusSet;
   logic [mct_pkg::ST_W-1:0]      statusClr;
   mct_pkg::count_mode_e          mode;
   logic                          running;
   logic                          preTerm;
   logic                          edgeTick;
   logic                          advance;
   logic                          capClear;
   logic                          hitReset;
   logic                          hitStop;
   logic                          clrSel;

   function automatic logic [mct_pkg::DATA_W-1:0] zext(input logic [CNT_W-1:0] v);
      logic [mct_pkg::DATA_W-1:0] r;
      r = '0;
      r[CNT_W-1:0] = v;
      return r;
   endfunction : zext

   function automatic logic wrAt(input logic [mct_pkg::ADDR_W-1:0] ofs);
      return wrStb && (addr == ofs);
   endfunction : wrAt

   match_unit u_match (
      .mclk (mclk),
      .rstn (rstn),
      .bus  (bus.match)
   );

   capture_unit u_capture (
      .mclk  (mclk),
      .rstn  (rstn),
      .capIn (capIn),
      .bus   (bus.cap)
   );

   assign bus.count = countQ;

   always_comb begin
      for (int i = 0; i < NM; i++) begin
         bus.matchVal[i] = matchQ[i];
         matchInt[i]     = matchCtrlQ[i*mct_pkg::MC_W + mct_pkg::MC_INT];
         matchRst[i]     = matchCtrlQ[i*mct_pkg::MC_W + mct_pkg::MC_RST];
         matchStop[i]    = matchCtrlQ[i*mct_pkg::MC_W + mct_pkg::MC_STOP];
      end
      for (int c = 0; c < NC; c++) begin
         bus.capRiseEn[c] = capCtrlQ[c*mct_pkg::CC_W + mct_pkg::CC_RISE];
         bus.capFallEn[c] = capCtrlQ[c*mct_pkg::CC_W + mct_pkg::CC_FALL];
         capInt[c]        = capCtrlQ[c*mct_pkg::CC_W + mct_pkg::CC_INT];
      end
   end

   // Count source selection
   assign mode    = mct_pkg::count_mode_e'(countCtrlQ[mct_pkg::CM_MODE_LSB +: 2]);
   assign running = ctrlQ[mct_pkg::CTRL_EN] & ~ctrlQ[mct_pkg::CTRL_RST];
   assign preTerm = (preCountQ == prescaleQ);

   always_comb begin
      unique case (mode)
         mct_pkg::MODE_TIMER: edgeTick = 1'b0;
         mct_pkg::MODE_RISE:  edgeTick = bus.capRise[countCtrlQ[mct_pkg::CM_SEL]];
         mct_pkg::MODE_FALL:  edgeTick = bus.capFall[countCtrlQ[mct_pkg::CM_SEL]];
         mct_pkg::MODE_BOTH:  edgeTick = bus.capRise[countCtrlQ[mct_pkg::CM_SEL]]
                                       | bus.capFall[countCtrlQ[mct_pkg::CM_SEL]];
      endcase
   end

   // A stop hit freezes the count at the match value, not one past it
   assign advance = running & ~hitStop
                  & ((mode == mct_pkg::MODE_TIMER) ? preTerm : edgeTick);

   // Designated capture edge clears count and prescaler
   assign clrSel   = countCtrlQ[mct_pkg::CM_CLR_SEL];
   assign capClear = countCtrlQ[mct_pkg::CM_CLR_EN]
                   & (countCtrlQ[mct_pkg::CM_CLR_FALL] ? bus.capFall[clrSel]
                                                       : bus.capRise[clrSel]);

   assign hitReset = |(bus.matchHit & matchRst);
   assign hitStop  = |(bus.matchHit & matchStop);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         countQ <= '0;
      end else if (ctrlQ[mct_pkg::CTRL_RST] || capClear) begin
         countQ <= '0;
      end else if (wrAt(mct_pkg::OFS_COUNT)) begin
         countQ <= wdata[CNT_W-1:0];
      end else if (hitReset) begin
         countQ <= '0;
      end else if (advance) begin
         countQ <= countQ + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         preCountQ <= '0;
      end else if (ctrlQ[mct_pkg::CTRL_RST] || capClear) begin
         preCountQ <= '0;
      end else if (running && !hitStop && mode == mct_pkg::MODE_TIMER) begin
         preCountQ <= preTerm ? '0 : preCountQ + 1'b1;
      end
   end

   // Stop wins over a simultaneous enable write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrlQ <= '0;
      end else begin
         if (wrAt(mct_pkg::OFS_CTRL)) begin
            ctrlQ <= wdata[mct_pkg::CTRL_W-1:0];
         end
         if (hitStop) begin
            ctrlQ[mct_pkg::CTRL_EN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         maskQ <= '0;
      end else if (wrAt(mct_pkg::OFS_MASK)) begin
         maskQ <= wdata[mct_pkg::ST_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prescaleQ <= '0;
      end else if (wrAt(mct_pkg::OFS_PRESCALE)) begin
         prescaleQ <= wdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         matchCtrlQ <= '0;
      end else if (wrAt(mct_pkg::OFS_MATCHCTRL)) begin
         matchCtrlQ <= wdata[NM*mct_pkg::MC_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         outCtrlQ <= '0;
      end else if (wrAt(mct_pkg::OFS_OUTCTRL)) begin
         outCtrlQ <= wdata[NM*mct_pkg::OUT_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         capCtrlQ <= '0;
      end else if (wrAt(mct_pkg::OFS_CAPCTRL)) begin
         capCtrlQ <= wdata[NC*mct_pkg::CC_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         countCtrlQ <= '0;
      end else if (wrAt(mct_pkg::OFS_COUNTCTRL)) begin
         countCtrlQ <= wdata[mct_pkg::CM_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NM; i++) begin
            matchQ[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NM; i++) begin
            if (wrAt(mct_pkg::OFS_MATCH0 + 8'(4 * i))) begin
               matchQ[i] <= wdata[CNT_W-1:0];
            end
         end
      end
   end

   // Match outputs; a match action wins over a software write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         outQ <= '0;
      end else begin
         for (int i = 0; i < NM; i++) begin
            if (bus.matchHit[i]) begin
               unique case (mct_pkg::out_act_e'(outCtrlQ[i*mct_pkg::OUT_W +: mct_pkg::OUT_W]))
                  mct_pkg::ACT_NONE:   outQ[i] <= outQ[i];
                  mct_pkg::ACT_LOW:    outQ[i] <= 1'b0;
                  mct_pkg::ACT_HIGH:   outQ[i] <= 1'b1;
                  mct_pkg::ACT_TOGGLE: outQ[i] <= ~outQ[i];
               endcase
            end else if (wrAt(mct_pkg::OFS_OUTVAL)) begin
               outQ[i] <= wdata[i];
            end
         end
      end
   end

   assign matchOut = outQ;

   // Flags: hardware set wins over the write-one clear in the same cycle
   assign statusSet = {bus.capEvt & capInt, bus.matchHit & matchInt};
   assign statusClr = wrAt(mct_pkg::OFS_STATUS) ? wdata[mct_pkg::ST_W-1:0] : '0;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         statusQ <= '0;
      end else begin
         statusQ <= (statusQ & ~statusClr) | statusSet;
      end
   end

   assign irq = |(statusQ & maskQ);

   always_comb begin
      rdMux = mct_pkg::REG_RESET;
      unique case (addr)
         mct_pkg::OFS_STATUS:    rdMux[mct_pkg::ST_W-1:0] = statusQ;
         mct_pkg::OFS_MASK:      rdMux[mct_pkg::ST_W-1:0] = maskQ;
         mct_pkg::OFS_CTRL:      rdMux[mct_pkg::CTRL_W-1:0] = ctrlQ;
         mct_pkg::OFS_COUNT:     rdMux = zext(countQ);
         mct_pkg::OFS_PRESCALE:  rdMux = zext(prescaleQ);
         mct_pkg::OFS_PRECOUNT:  rdMux = zext(preCountQ);
         mct_pkg::OFS_MATCHCTRL: rdMux[NM*mct_pkg::MC_W-1:0] = matchCtrlQ;
         mct_pkg::OFS_OUTCTRL:   rdMux[NM*mct_pkg::OUT_W-1:0] = outCtrlQ;
         mct_pkg::OFS_CAPCTRL:   rdMux[NC*mct_pkg::CC_W-1:0] = capCtrlQ;
         mct_pkg::OFS_COUNTCTRL: rdMux[mct_pkg::CM_W-1:0] = countCtrlQ;
         mct_pkg::OFS_OUTVAL:    rdMux[NM-1:0] = outQ;
         mct_pkg::OFS_MATCH0:    rdMux = zext(matchQ[0]);
         mct_pkg::OFS_MATCH0 + 8'h04: rdMux = zext(matchQ[1]);
         mct_pkg::OFS_MATCH0 + 8'h08: rdMux = zext(matchQ[2]);
         mct_pkg::OFS_MATCH0 + 8'h0C: rdMux = zext(matchQ[3]);
         mct_pkg::OFS_CAP0:           rdMux = zext(bus.capVal[0]);
         mct_pkg::OFS_CAP0 + 8'h04:   rdMux = zext(bus.capVal[1]);
         default: ;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdataQ <= '0;
      end else begin
         rdataQ <= rdStb ? rdMux : '0;
      end
   end

   assign rdata = rdataQ;

endmodule : match_capture_counter_timer

// ==== dv/mct_asserts.sv ====
`timescale 1ns/1ps
module mct_asserts #(
   parameter int CNT_W = 32
) (
   input wire logic                          mclk,
   input wire logic                          rstn,
   input wire logic [mct_pkg::ADDR_W-1:0]    addr,
   input wire logic [mct_pkg::DATA_W-1:0]    wdata,
   input wire logic                          wrStb,
   input wire logic                          rdStb,
   input wire logic [mct_pkg::DATA_W-1:0]    rdata,
   input wire logic [mct_pkg::NUM_CAP-1:0]   capIn,
   input wire logic [mct_pkg::NUM_MATCH-1:0] matchOut,
   input wire logic                          irq
);
   logic [mct_pkg::ST_W-1:0] maskQ;
   logic [7:0]               outCtlQ;

   // Shadows of bus writes, so irq and outputs can be tied to their setup
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         maskQ <= '0;
      end else if (wrStb && addr == mct_pkg::OFS_MASK) begin
         maskQ <= wdata[mct_pkg::ST_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         outCtlQ <= '0;
      end else if (wrStb && addr == mct_pkg::OFS_OUTCTRL) begin
         outCtlQ <= wdata[7:0];
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   chk_rdata_idle: assert property (!$past(rdStb) |-> rdata == '0)
      else $error("read data not zero outside its slot");
   chk_unmapped_zero: assert property (rdStb && addr == 8'hFC |=> rdata == '0)
      else $error("unmapped read not zero");
   chk_count_width: assert property (
      $past(rdStb) && $past(addr) == mct_pkg::OFS_COUNT |-> (rdata >> CNT_W) == '0)
      else $error("count wider than counter");
   chk_prescale_width: assert property (
      $past(rdStb) && $past(addr) == mct_pkg::OFS_PRECOUNT |-> (rdata >> CNT_W) == '0)
      else $error("prescaler wider than counter");
   chk_capture_width: assert property (
      $past(rdStb) && $past(addr) == mct_pkg::OFS_CAP0 |-> (rdata >> CNT_W) == '0)
      else $error("capture wider than counter");
   chk_status_width: assert property (
      $past(rdStb) && $past(addr) == mct_pkg::OFS_STATUS |-> (rdata >> mct_pkg::ST_W) == '0)
      else $error("status has extra bits");
   chk_irq_masked: assert property (maskQ == '0 && $past(maskQ) == '0 |-> !irq)
      else $error("irq with all flags masked");
   chk_irq_sticky: assert property ($fell(irq) |-> $past(wrStb) || $past(wrStb, 2))
      else $error("irq dropped without a write");
   chk_out_hold: assert property ($changed(matchOut) |->
      ($past(wrStb) && $past(addr) == mct_pkg::OFS_OUTVAL) || outCtlQ != '0
      || $past(outCtlQ) != '0)
      else $error("match output moved with no action set");
endmodule : mct_asserts

bind match_capture_counter_timer mct_asserts #(.CNT_W(CNT_W)) chk (
   .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wrStb(wrStb),
   .rdStb(rdStb), .rdata(rdata), .capIn(capIn), .matchOut(matchOut), .irq(irq));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic                          mclk;
   logic                          rstn;
   logic [mct_pkg::ADDR_W-1:0]    addr;
   logic [mct_pkg::DATA_W-1:0]    wdata;
   logic                          wrStb;
   logic                          rdStb;
   logic [mct_pkg::DATA_W-1:0]    rdata;
   logic [mct_pkg::NUM_CAP-1:0]   capIn;
   logic [mct_pkg::NUM_MATCH-1:0] matchOut;
   logic                          irq;
   int                            error_cnt;
   int                            n_checks;

   // Narrow build: upper bits of every count must read zero
   match_capture_counter_timer #(.CNT_W(16)) dut (
      .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wrStb(wrStb),
      .rdStb(rdStb), .rdata(rdata), .capIn(capIn), .matchOut(matchOut), .irq(irq));

   always #12.5 mclk = ~mclk;

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge mclk);
      wrStb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      rdStb <= 1'b1;
      @(posedge mclk);
      rdStb <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      cmp($sformatf("reg %h", a), e, v);
   endtask : rc

   task automatic t_reset;
      logic [7:0] regs [12] = '{mct_pkg::OFS_STATUS, mct_pkg::OFS_MASK, mct_pkg::OFS_CTRL,
         mct_pkg::OFS_COUNT, mct_pkg::OFS_PRESCALE, mct_pkg::OFS_MATCHCTRL,
         mct_pkg::OFS_OUTCTRL, mct_pkg::OFS_CAPCTRL, mct_pkg::OFS_COUNTCTRL,
         mct_pkg::OFS_OUTVAL, mct_pkg::OFS_MATCH0, mct_pkg::OFS_CAP0};
      foreach (regs[i]) rc(regs[i], mct_pkg::REG_RESET);
      wr(8'hFC, 32'hFFFF_FFFF);
      rc(8'hFC, 32'h0);
      wr(mct_pkg::OFS_COUNT, 32'h0001_FFFF);
      rc(mct_pkg::OFS_COUNT, 32'h0000_FFFF);
      wr(mct_pkg::OFS_PRESCALE, 32'hABCD_1234);
      rc(mct_pkg::OFS_PRESCALE, 32'h0000_1234);
      $display("reset and width test done");
   endtask : t_reset

   task automatic t_stop;
      wr(mct_pkg::OFS_PRESCALE, 32'h3);
      wr(mct_pkg::OFS_COUNT, 32'h0);
      wr(mct_pkg::OFS_MATCH0, 32'h5);
      wr(mct_pkg::OFS_MATCHCTRL, 32'h5);
      wr(mct_pkg::OFS_MASK, 32'h1);
      wr(mct_pkg::OFS_CTRL, 32'h1);
      repeat (40) @(posedge mclk);
      rc(mct_pkg::OFS_COUNT, 32'h5);
      rc(mct_pkg::OFS_CTRL, 32'h0);
      rc(mct_pkg::OFS_STATUS, 32'h1);
      cmp("irq", 32'h1, 32'(irq));
      wr(mct_pkg::OFS_STATUS, 32'h1);
      rc(mct_pkg::OFS_STATUS, 32'h0);
      cmp("irq", 32'h0, 32'(irq));
      $display("stop on match test done");
   endtask : t_stop

   task automatic t_reset_match;
      logic [31:0] v;
      wr(mct_pkg::OFS_PRESCALE, 32'h0);
      wr(mct_pkg::OFS_MATCHCTRL, 32'h18);
      wr(mct_pkg::OFS_MATCH0 + 8'h04, 32'h3);
      wr(mct_pkg::OFS_MASK, 32'h0);
      wr(mct_pkg::OFS_COUNT, 32'h0);
      wr(mct_pkg::OFS_CTRL, 32'h1);
      repeat (3) begin
         rd(mct_pkg::OFS_COUNT, v);
         cmp("count below match", 32'h1, 32'(v <= 3));
      end
      cmp("irq masked", 32'h0, 32'(irq));
      wr(mct_pkg::OFS_MASK, 32'h2);
      @(negedge mclk);
      cmp("irq unmasked", 32'h1, 32'(irq));
      wr(mct_pkg::OFS_CTRL, 32'h0);
      rc(mct_pkg::OFS_STATUS, 32'h2);
      wr(mct_pkg::OFS_STATUS, 32'h2);
      @(negedge mclk);
      cmp("irq cleared", 32'h0, 32'(irq));
      wr(mct_pkg::OFS_MATCHCTRL, 32'h200);
      wr(mct_pkg::OFS_MATCH0 + 8'h0C, 32'h4);
      wr(mct_pkg::OFS_COUNT, 32'h0);
      wr(mct_pkg::OFS_CTRL, 32'h1);
      repeat (20) @(posedge mclk);
      wr(mct_pkg::OFS_CTRL, 32'h0);
      rd(mct_pkg::OFS_COUNT, v);
      cmp("count past match", 32'h1, 32'(v > 4));
      rc(mct_pkg::OFS_STATUS, 32'h8);
      wr(mct_pkg::OFS_STATUS, 32'h8);
      $display("reset and continue test done");
   endtask : t_reset_match

   task automatic t_out;
      logic [1:0] act [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
      logic [3:0] init [5] = '{4'h4, 4'h4, 4'h0, 4'h0, 4'h4};
      logic [3:0] expv [5] = '{4'h4, 4'h0, 4'h4, 4'h4, 4'h0};
      wr(mct_pkg::OFS_MATCHCTRL, 32'h100);
      wr(mct_pkg::OFS_MATCH0 + 8'h08, 32'h2);
      for (int i = 0; i < 5; i++) begin
         wr(mct_pkg::OFS_OUTCTRL, 32'(act[i]) << 4);
         wr(mct_pkg::OFS_OUTVAL, 32'(init[i]));
         wr(mct_pkg::OFS_COUNT, 32'h0);
         wr(mct_pkg::OFS_CTRL, 32'h1);
         repeat (10) @(posedge mclk);
         cmp("match outputs", 32'(expv[i]), 32'(matchOut));
      end
      wr(mct_pkg::OFS_OUTCTRL, 32'h0);
      $display("match output test done");
   endtask : t_out

   task automatic t_capture;
      logic [31:0] v;
      wr(mct_pkg::OFS_MATCHCTRL, 32'h0);
      wr(mct_pkg::OFS_CAPCTRL, 32'h5);
      wr(mct_pkg::OFS_MASK, 32'h10);
      wr(mct_pkg::OFS_COUNT, 32'h0);
      wr(mct_pkg::OFS_CTRL, 32'h1);
      repeat (20) @(posedge mclk);
      capIn[0] <= 1'b1;
      repeat (10) @(posedge mclk);
      cmp("irq capture", 32'h1, 32'(irq));
      rc(mct_pkg::OFS_STATUS, 32'h10);
      wr(mct_pkg::OFS_CAP0, 32'h0);
      rd(mct_pkg::OFS_CAP0, v);
      cmp("capture value", 32'h1, 32'(v >= 20 && v <= 28));
      wr(mct_pkg::OFS_COUNTCTRL, 32'h18);
      repeat (30) @(posedge mclk);
      capIn[0] <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(mct_pkg::OFS_COUNT, v);
      cmp("count after clear", 32'h1, 32'(v < 12));
      wr(mct_pkg::OFS_STATUS, 32'h10);
      @(negedge mclk);
      cmp("irq capture clear", 32'h0, 32'(irq));
      wr(mct_pkg::OFS_CTRL, 32'h3);
      rc(mct_pkg::OFS_COUNT, 32'h0);
      rc(mct_pkg::OFS_PRECOUNT, 32'h0);
      $display("capture test done");
   endtask : t_capture

   task automatic t_counter;
      logic [31:0] expv [3] = '{32'h3, 32'h3, 32'h6};
      for (int m = 1; m < 4; m++) begin
         wr(mct_pkg::OFS_CTRL, 32'h0);
         wr(mct_pkg::OFS_COUNTCTRL, 32'h4 | 32'(m));
         wr(mct_pkg::OFS_COUNT, 32'h0);
         wr(mct_pkg::OFS_CTRL, 32'h1);
         repeat (3) begin
            capIn[1] <= 1'b1;
            repeat (6) @(posedge mclk);
            capIn[1] <= 1'b0;
            repeat (6) @(posedge mclk);
         end
         repeat (6) @(posedge mclk);
         rc(mct_pkg::OFS_COUNT, expv[m-1]);
      end
      $display("counter mode test done");
   endtask : t_counter

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   initial begin
      mclk  = 1'b0;
      rstn  = 1'b0;
      addr  = '0;
      wdata = '0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      capIn = '0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_stop();
      t_reset_match();
      t_out();
      t_capture();
      t_counter();
      end_sim();
   end

   // Whole run is near 500 cycles; this leaves ample margin
   initial begin
      repeat (6000) @(posedge mclk);
      error_cnt++;
      $display("unexpected watchdog: expected end seen hang");
      end_sim();
   end
endmodule : tb_top
